// [src/lmspd_top.sv]
`timescale 1ns/10ps
// Contract
// - rate select only changes while the unlock bit is one
// - select codes 000/111 full rate, each step halves it
// - select resets to 000; low five bits unused
// - four row switches turn on one at a time in sequence
// - row outputs active high, only during own slot
// - slot of 33 us then gaps of 0.83 and 0.3 us; code rounds the first gap up to 9 cycles, 0.9 us
// - row duty over full scan about one in 4.14
// - sink on for pwm value over 256 of slot
// - pwm is the only brightness mode
// - pwm value equals step count, four means four 256ths
// - one open/short result bit per led
// - trigger 00 to 01 or 10 starts result capture
// - results done within two scan cycles of trigger
// - results in 53h to 5eh, six bits per register
// - leds with zero dot scaling keep their result bits
// - one pass per trigger transition, never repeated
// - 01 open test, 10 short test, 00 disabled
module lmspd_top (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// register port, same clock domain
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// led data, flat per led
	input wire logic [lmspd_pkg::LEDS*8-1:0] pwm_val_i,
	input wire logic [lmspd_pkg::LEDS-1:0] dot_on_i,
	// analog fault sense per column, raw pins
	input wire logic [lmspd_pkg::COLS-1:0] col_fault_i,
	// matrix drive
	output logic [lmspd_pkg::ROWS-1:0] row_switch_o,
	output logic [lmspd_pkg::COLS-1:0] column_sink_o,
	output logic [1:0] detect_mode_o
);
	// register state
	logic [2:0] rate_sel_r, rate_sel_nxt;
	logic unlock_r, unlock_nxt;
	logic [1:0] trig_r, trig_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic soft_rst;
	logic rd_pend_r, rd_pend_nxt;
	logic [5:0] mem_rd;

	// fault input three-stage synchroniser
	logic [lmspd_pkg::COLS-1:0] f1_r, f2_r, f3_r, fault_r;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			f1_r <= '0;
			f2_r <= '0;
			f3_r <= '0;
			fault_r <= '0;
		end else begin
			f1_r <= col_fault_i;
			f2_r <= f1_r;
			f3_r <= f2_r;
			if (f2_r == f3_r) begin
				fault_r <= f3_r;
			end
		end
	end

	function automatic logic is_result(input logic [7:0] a);
		return a >= lmspd_pkg::OFS_RES_FIRST && a <= lmspd_pkg::OFS_RES_LAST;
	endfunction

	assign soft_rst = reg_wr_i && reg_addr_i == lmspd_pkg::OFS_RESET
		&& reg_wdata_i == lmspd_pkg::RESET_KEY;

	always_comb begin
		rate_sel_nxt = rate_sel_r;
		unlock_nxt = unlock_r;
		trig_nxt = trig_r;
		rd_pend_nxt = 1'b0;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				lmspd_pkg::OFS_CONFIG: trig_nxt = reg_wdata_i[lmspd_pkg::TRIG_LSB +: 2];
				lmspd_pkg::OFS_RATE_UNLOCK: unlock_nxt = reg_wdata_i[lmspd_pkg::UNLOCK_BIT];
				lmspd_pkg::OFS_RATE_SEL: begin
					if (unlock_r) begin
						rate_sel_nxt = reg_wdata_i[lmspd_pkg::RATE_LSB +: 3];
					end
				end
				default: ;
			endcase
		end
		// result reads take two cycles: memory output is registered
		if (reg_rd_i) begin
			if (is_result(reg_addr_i)) begin
				rd_pend_nxt = 1'b1;
			end else begin
				rvalid_nxt = 1'b1;
				rdata_nxt = (reg_addr_i == lmspd_pkg::OFS_CONFIG)
					? {5'h00, trig_r, 1'b0} : 8'h00;
			end
		end
		if (rd_pend_r) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {2'b00, mem_rd};
		end
		if (soft_rst) begin
			rate_sel_nxt = lmspd_pkg::RATE_SEL_RST;
			unlock_nxt = 1'b0;
			trig_nxt = lmspd_pkg::TRIG_RST;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rate_sel_r <= lmspd_pkg::RATE_SEL_RST;
			unlock_r <= 1'b0;
			trig_r <= lmspd_pkg::TRIG_RST;
			rd_pend_r <= 1'b0;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rate_sel_r <= rate_sel_nxt;
			unlock_r <= unlock_nxt;
			trig_r <= trig_nxt;
			rd_pend_r <= rd_pend_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// pwm rate: prescale the 256-step counter by 2**code; 111 aliases 000
	logic [2:0] shift;
	assign shift = (rate_sel_r == 3'h7) ? 3'h0 : rate_sel_r;
	logic [5:0] pre_r, pre_nxt;
	logic tick;
	// compare with >= so a lowered code cannot strand the prescaler past its new limit
	assign tick = (pre_r >= ((6'h01 << shift) - 6'h01));

	// scan sequencer: the tick steps the pwm count; slot ends on the scan count
	lmspd_pkg::lmspd_phase_t ph_r, ph_nxt;
	logic [9:0] tcnt_r, tcnt_nxt;
	logic [1:0] row_r, row_nxt;
	logic [7:0] pcnt_r, pcnt_nxt;
	logic scan_done;

	always_comb begin
		ph_nxt = ph_r;
		tcnt_nxt = tcnt_r + 10'h001;
		row_nxt = row_r;
		pcnt_nxt = pcnt_r;
		pre_nxt = tick ? 6'h00 : pre_r + 6'h01;
		scan_done = 1'b0;
		case (ph_r)
			lmspd_pkg::PH_ON: begin
				if (tick) begin
					pcnt_nxt = pcnt_r + 8'h01;
				end
				if (tcnt_r == 10'(lmspd_pkg::CYC_SCAN - 1)) begin
					ph_nxt = lmspd_pkg::PH_NOL1;
					tcnt_nxt = 10'h000;
				end
			end
			lmspd_pkg::PH_NOL1: begin
				if (tcnt_r == 10'(lmspd_pkg::CYC_NOL1 - 1)) begin
					ph_nxt = lmspd_pkg::PH_NOL2;
					tcnt_nxt = 10'h000;
				end
			end
			lmspd_pkg::PH_NOL2: begin
				if (tcnt_r == 10'(lmspd_pkg::CYC_NOL2 - 1)) begin
					ph_nxt = lmspd_pkg::PH_ON;
					tcnt_nxt = 10'h000;
					row_nxt = row_r + 2'h1;
					scan_done = (row_r == 2'(lmspd_pkg::ROWS - 1));
				end
			end
			default: begin
				ph_nxt = lmspd_pkg::PH_ON;
				tcnt_nxt = 10'h000;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i || soft_rst) begin
			// park at the end of the last gap so row 0 gets a full first slot
			ph_r <= lmspd_pkg::PH_NOL2;
			tcnt_r <= 10'(lmspd_pkg::CYC_NOL2 - 1);
			row_r <= 2'(lmspd_pkg::ROWS - 1);
			pcnt_r <= 8'h00;
			pre_r <= 6'h00;
		end else begin
			ph_r <= ph_nxt;
			tcnt_r <= tcnt_nxt;
			row_r <= row_nxt;
			pcnt_r <= pcnt_nxt;
			pre_r <= pre_nxt;
		end
	end

	// outputs: row during its slot only; duty = 330/(330+9+3)/4, about 1/4.14
	logic [lmspd_pkg::ROWS-1:0] row_sw_r, row_sw_nxt;
	logic [lmspd_pkg::COLS-1:0] sink_r, sink_nxt;
	always_comb begin
		row_sw_nxt = '0;
		sink_nxt = '0;
		if (ph_nxt == lmspd_pkg::PH_ON) begin
			row_sw_nxt[row_nxt] = 1'b1;
			for (int c = 0; c < lmspd_pkg::COLS; c++) begin
				// only pwm mode; compare gives value/256 on-time
				sink_nxt[c] = pcnt_nxt < pwm_val_i[(row_nxt*lmspd_pkg::COLS+c)*8 +: 8];
			end
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (srst_i || soft_rst) begin
			row_sw_r <= '0;
			sink_r <= '0;
		end else begin
			row_sw_r <= row_sw_nxt;
			sink_r <= sink_nxt;
		end
	end

	// detection: arm on a 00 -> 01/10 edge, wait one scan, capture over the next
	lmspd_pkg::lmspd_det_t dt_r, dt_nxt;
	logic [1:0] trig_prev_r;
	logic [1:0] mode_r, mode_nxt;
	logic [lmspd_pkg::LEDS-1:0] res_r, res_nxt;
	logic [lmspd_pkg::LEDS-1:0] hold_r, hold_nxt;
	logic capt;
	logic [3:0] waddr_r, waddr_nxt;
	logic wr_en;
	logic trig_edge;
	assign trig_edge = trig_prev_r == lmspd_pkg::TRIG_OFF
		&& (trig_r == lmspd_pkg::TRIG_OPEN || trig_r == lmspd_pkg::TRIG_SHORT);
	assign capt = dt_r == lmspd_pkg::DT_RUN && ph_r == lmspd_pkg::PH_ON
		&& tcnt_r == 10'(lmspd_pkg::CYC_SCAN - 1);

	always_comb begin
		dt_nxt = dt_r;
		mode_nxt = mode_r;
		res_nxt = res_r;
		hold_nxt = hold_r;
		waddr_nxt = 4'h0;
		wr_en = 1'b0;
		case (dt_r)
			lmspd_pkg::DT_IDLE: begin
				if (trig_edge) begin
					dt_nxt = lmspd_pkg::DT_WAIT;
					mode_nxt = trig_r;
					hold_nxt = ~dot_on_i;
				end
			end
			lmspd_pkg::DT_WAIT: begin
				if (scan_done) begin
					dt_nxt = lmspd_pkg::DT_RUN;
				end
			end
			lmspd_pkg::DT_RUN: begin
				if (capt) begin
					for (int c = 0; c < lmspd_pkg::COLS; c++) begin
						if (!hold_r[row_r*lmspd_pkg::COLS+c]) begin
							res_nxt[row_r*lmspd_pkg::COLS+c] = fault_r[c];
						end
					end
				end
				if (scan_done) begin
					dt_nxt = lmspd_pkg::DT_IDLE;
					mode_nxt = lmspd_pkg::TRIG_OFF;
				end
			end
			default: dt_nxt = lmspd_pkg::DT_IDLE;
		endcase
		// stream results into the readable memory one word per idle cycle
		if (dt_r == lmspd_pkg::DT_IDLE) begin
			wr_en = 1'b1;
			waddr_nxt = (waddr_r == 4'(lmspd_pkg::RES_REGS - 1)) ? 4'h0 : waddr_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i || soft_rst) begin
			dt_r <= lmspd_pkg::DT_IDLE;
			trig_prev_r <= lmspd_pkg::TRIG_RST;
			mode_r <= lmspd_pkg::TRIG_OFF;
			res_r <= '0;
			hold_r <= '0;
			waddr_r <= 4'h0;
		end else begin
			dt_r <= dt_nxt;
			trig_prev_r <= trig_r;
			mode_r <= mode_nxt;
			res_r <= res_nxt;
			hold_r <= hold_nxt;
			waddr_r <= waddr_nxt;
		end
	end

	lmspd_result_mem u_mem (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i || soft_rst),
		.wr_en_i(wr_en),
		.wr_addr_i(waddr_r),
		.wr_data_i(res_r[waddr_r*lmspd_pkg::RES_BITS +: lmspd_pkg::RES_BITS]),
		.rd_addr_i(4'(reg_addr_i - lmspd_pkg::OFS_RES_FIRST)),
		.rd_data_o(mem_rd)
	);

	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign row_switch_o = row_sw_r;
	assign column_sink_o = sink_r;
	assign detect_mode_o = mode_r;
endmodule

// [src/lmspd_pkg.sv]
package lmspd_pkg;
	// scan geometry
	localparam int ROWS = 4;
	localparam int COLS = 18;
	localparam int LEDS = ROWS * COLS;
	localparam int RES_BITS = 6;
	localparam int RES_REGS = LEDS / RES_BITS;
	// register offsets
	localparam logic [7:0] OFS_CONFIG = 8'h50;
	localparam logic [7:0] OFS_RES_FIRST = 8'h53;
	localparam logic [7:0] OFS_RES_LAST = 8'h5e;
	localparam logic [7:0] OFS_RESET = 8'h8f;
	localparam logic [7:0] OFS_RATE_UNLOCK = 8'he0;
	localparam logic [7:0] OFS_RATE_SEL = 8'he2;
	localparam logic [7:0] RESET_KEY = 8'hae;
	// field positions and reset values
	localparam int TRIG_LSB = 1;
	localparam int UNLOCK_BIT = 0;
	localparam int RATE_LSB = 5;
	localparam logic [2:0] RATE_SEL_RST = 3'h0;
	localparam logic [1:0] TRIG_RST = 2'h0;
	localparam logic [1:0] TRIG_OFF = 2'h0;
	localparam logic [1:0] TRIG_OPEN = 2'h1;
	localparam logic [1:0] TRIG_SHORT = 2'h2;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int T_SCAN_NS = 33000;
	localparam int T_NOL1_NS = 830;
	localparam int T_NOL2_NS = 300;
	localparam int NS_PER_CYC = 1_000_000_000 / CLK_HZ;
	localparam int CYC_SCAN = T_SCAN_NS / NS_PER_CYC;
	localparam int CYC_NOL1 = (T_NOL1_NS + NS_PER_CYC - 1) / NS_PER_CYC;
	localparam int CYC_NOL2 = (T_NOL2_NS + NS_PER_CYC - 1) / NS_PER_CYC;
	localparam int DETECT_SCANS = 2;
	typedef enum logic [1:0] {PH_ON, PH_NOL1, PH_NOL2} lmspd_phase_t;
	typedef enum logic [1:0] {DT_IDLE, DT_WAIT, DT_RUN} lmspd_det_t;
endpackage

// [src/lmspd_result_mem.sv]
`timescale 1ns/10ps
// twelve six-bit result words; read data registered
module lmspd_result_mem (
	// clock
	input wire logic core_clk_i,
	input wire logic srst_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [3:0] wr_addr_i,
	input wire logic [5:0] wr_data_i,
	// read port
	input wire logic [3:0] rd_addr_i,
	output logic [5:0] rd_data_o
);
	logic [5:0] mem_r [0:11];
	logic [5:0] rd_r;
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < 12; i++) begin
				mem_r[i] <= 6'h00;
			end
			rd_r <= 6'h00;
		end else begin
			if (wr_en_i && wr_addr_i < 4'd12) begin
				mem_r[wr_addr_i] <= wr_data_i;
			end
			rd_r <= (rd_addr_i < 4'd12) ? mem_r[rd_addr_i] : 6'h00;
		end
	end
	assign rd_data_o = rd_r;
endmodule

// [dv/lmspd_scan_chk.sv]
`timescale 1ns/10ps
module lmspd_scan_chk (
	// clock
	input wire logic core_clk_i,
	input wire logic srst_i,
	// register port
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	// matrix
	input wire logic [lmspd_pkg::LEDS*8-1:0] pwm_val_i,
	input wire logic [lmspd_pkg::ROWS-1:0] row_switch_o,
	input wire logic [lmspd_pkg::COLS-1:0] column_sink_o,
	input wire logic [1:0] detect_mode_o
);
	logic [8:0] on_r, on_nxt;
	logic [11:0] det_r, det_nxt;
	logic res_rd;
	assign res_rd = reg_rd_i && reg_addr_i >= lmspd_pkg::OFS_RES_FIRST
		&& reg_addr_i <= lmspd_pkg::OFS_RES_LAST;
	always_comb begin
		on_nxt = (srst_i || row_switch_o == '0) ? 9'h0 : on_r + 9'h1;
		det_nxt = (srst_i || detect_mode_o == '0) ? 12'h0 : det_r + 12'h1;
	end
	always_ff @(posedge core_clk_i) begin
		on_r <= on_nxt;
		det_r <= det_nxt;
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	property p_one_row; $onehot0(row_switch_o); endproperty
	a_one_row: assert property (p_one_row) else $error("two rows on");
	property p_slot; $fell(|row_switch_o) |-> on_r == 9'h14a; endproperty
	a_slot: assert property (p_slot) else $error("slot length wrong");
	property p_gap;
		$fell(|row_switch_o) |-> (row_switch_o == '0)[*8] ##1 (row_switch_o == '0)[*4]
			##1 (row_switch_o != '0);
	endproperty
	a_gap: assert property (p_gap) else $error("gap length wrong");
	property p_order;
		$fell(|row_switch_o) |-> ##12
			($past(row_switch_o, 13) == {row_switch_o[0], row_switch_o[3:1]});
	endproperty
	a_order: assert property (p_order) else $error("row order wrong");
	property p_dark;
		$past(pwm_val_i == '0, 2) && $past(pwm_val_i == '0) |-> column_sink_o == '0;
	endproperty
	a_dark: assert property (p_dark) else $error("sink on at zero pwm");
	property p_res_rd;
		res_rd |-> ##1 !reg_rvalid_o ##1 (reg_rvalid_o && reg_rdata_o[7:6] == 2'h0);
	endproperty
	a_res_rd: assert property (p_res_rd) else $error("result read wrong");
	property p_reg_rd; reg_rd_i && !res_rd |=> reg_rvalid_o; endproperty
	a_reg_rd: assert property (p_reg_rd) else $error("read answer late");
	// counts from mode raise; two full scans of 4 x 342 cycles
	property p_det; det_r <= 12'hab0; endproperty
	a_det: assert property (p_det) else $error("detect too long");
	property p_mode; detect_mode_o != 2'h3; endproperty
	a_mode: assert property (p_mode) else $error("bad detect mode");
endmodule
bind lmspd_top lmspd_scan_chk u_chk (
	.core_clk_i(core_clk_i),
	.srst_i(srst_i),
	.reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i),
	.reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o),
	.pwm_val_i(pwm_val_i),
	.row_switch_o(row_switch_o),
	.column_sink_o(column_sink_o),
	.detect_mode_o(detect_mode_o)
);

// [dv/lmspd_matrix_model.sv]
`timescale 1ns/10ps
// fault sense is only seen while a row conducts and a test is armed
module lmspd_matrix_model #(
	parameter logic [71:0] OPEN_MASK = 72'h0,
	parameter logic [71:0] SHORT_MASK = 72'h0
) (
	// drive from the device
	input wire logic [3:0] row_switch_i,
	input wire logic [1:0] detect_mode_i,
	// sense back
	output logic [17:0] col_fault_o
);
	always_comb begin
		col_fault_o = '0;
		for (int r = 0; r < 4; r++) begin
			if (row_switch_i[r] && detect_mode_i == lmspd_pkg::TRIG_OPEN) begin
				col_fault_o |= OPEN_MASK[r*18+:18];
			end
			if (row_switch_i[r] && detect_mode_i == lmspd_pkg::TRIG_SHORT) begin
				col_fault_o |= SHORT_MASK[r*18+:18];
			end
		end
	end
endmodule

// [dv/test_led_matrix_scan_pwm_detect.sv]
`timescale 1ns/10ps
module test_led_matrix_scan_pwm_detect;
	localparam logic [71:0] OPN = 72'h80_0000_0000_0000_0081;
	localparam logic [71:0] SHT = 72'h22;
	logic clk = 0, srst = 1, wr = 0, rd = 0, rv;
	logic [7:0] addr = 0, wd = 0, rdat;
	logic [575:0] pwm = '0;
	logic [71:0] dot = '1;
	logic [17:0] flt, snk;
	logic [3:0] row;
	logic [1:0] mode;
	int err_total = 0, tests_run = 0, n, h;
	lmspd_top u_dut (.core_clk_i(clk), .srst_i(srst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
		.pwm_val_i(pwm), .dot_on_i(dot), .col_fault_i(flt), .row_switch_o(row),
		.column_sink_o(snk), .detect_mode_o(mode));
	lmspd_matrix_model #(.OPEN_MASK(OPN), .SHORT_MASK(SHT)) u_mx (.row_switch_i(row),
		.detect_mode_i(mode), .col_fault_o(flt));
	initial begin
		forever #50 clk = ~clk;
	end
	task print_verdict;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [63:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task wreg(input logic [7:0] a, d);
		@(posedge clk); #1 addr = a; wd = d; wr = 1;
		@(posedge clk); #1 wr = 0;
	endtask
	task rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk); #1 addr = a; rd = 1;
		@(posedge clk); #1 rd = 0;
		for (int i = 0; i < 4 && rv !== 1'b1; i++) begin
			@(posedge clk); #1;
		end
		d = rdat;
		chk(rv, 1'b1);
		if (rv !== 1'b1) print_verdict;
	endtask
	// one sink over 4096 cycles: pwm-driven falls (row still on) and high cycles
	task meas;
		logic p;
		n = 0; h = 0; p = 0;
		repeat (4096) begin
			@(posedge clk);
			#1;
			n += (p && !snk[0] && row != 4'h0);
			h += snk[0];
			p = snk[0];
		end
	endtask
	task wmode(input logic [1:0] m);
		for (int i = 0; i < 3000 && mode !== m; i++) begin
			@(posedge clk);
			#1;
		end
		chk(mode, m);
		if (mode !== m) print_verdict;
	endtask
	task rres(input logic [71:0] e);
		logic [7:0] d;
		for (int k = 0; k < 12; k++) begin
			rreg(8'h53 + 8'(k), d);
			chk(d, {2'h0, e[k*6+:6]});
		end
	endtask
	task t_rate;
		logic [7:0] d;
		rreg(8'h70, d);
		chk(d, 8'h00);
		rreg(8'he2, d);
		chk(d, 8'h00);
		pwm = {72{8'h80}};
		meas;
		chk(n >= 14, 1);
		wreg(8'he2, 8'h60);
		meas;
		chk(n >= 14, 1);
		wreg(8'he0, 8'h01);
		wreg(8'he2, 8'h60);
		meas;
		chk(n <= 10, 1);
		wreg(8'he2, 8'he0);
		meas;
		chk(n >= 14, 1);
		wreg(8'he2, 8'h00);
	endtask
	task t_steps;
		pwm = {72{8'h04}};
		meas;
		chk(h >= 54 && h <= 68, 1);
		pwm = '0;
		meas;
		chk(h, 0);
		// one fixed value of ten 256ths, as a host would write it
		pwm = {72{8'h0a}};
		meas;
		chk(h >= 146 && h <= 164, 1);
	endtask
	task t_detect;
		logic [7:0] d;
		wreg(8'h51, 8'h20);
		wreg(8'h52, 8'h00);
		wreg(8'h50, 8'h02);
		wmode(2'h1);
		wmode(2'h0);
		repeat (20) @(posedge clk);
		rres(OPN);
		rreg(8'h50, d);
		chk(d, 8'h02);
		wreg(8'h50, 8'h02);
		n = 0;
		repeat (1500) begin
			@(posedge clk);
			#1;
			n += (mode !== 2'h0);
		end
		chk(n, 0);
		rres(OPN);
		dot[0] = 0;
		wreg(8'h50, 8'h00);
		wreg(8'h50, 8'h04);
		wmode(2'h2);
		wmode(2'h0);
		repeat (20) @(posedge clk);
		rres((SHT & dot) | (OPN & ~dot));
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 srst = 0;
		t_rate;
		t_steps;
		t_detect;
		print_verdict;
	end
endmodule
